// ==== hdl/nested_irq_pkg.sv ====
package nested_irq_pkg;

  // ---------------------------------------------------------------
  // vector map
  // ---------------------------------------------------------------
  localparam int NUM_VEC = 14;
  localparam logic [3:0] VEC_TOP_PIN = 4'h0;
  localparam logic [3:0] VEC_CLOCK_SEC = 4'h1;
  localparam logic [3:0] VEC_EXT_ZERO = 4'h2;
  localparam logic [3:0] VEC_UNUSED = 4'h6;
  localparam logic [3:0] VEC_SERIAL_SYNC = 4'h7;
  localparam logic [3:0] VEC_AUTORELOAD = 4'hD;
  localparam logic [15:0] ADDR_RESET_VEC = 16'hFFFE;
  localparam logic [15:0] ADDR_TRAP_VEC = 16'hFFFC;
  localparam logic [15:0] ADDR_VEC0 = 16'hFFFA;

  // vectors always able to leave halt: top pin and the four ext lines
  localparam logic [13:0] HALT_WAKE_FIXED = 14'h003D;
  // vectors fed by synchronised pins (edge events)
  localparam logic [13:0] PIN_VEC_MASK = 14'h003D;
  // vectors fed by peripheral flag and enable
  localparam logic [13:0] PERIPH_VEC_MASK = 14'h3F82;
  localparam int NUM_PINS = 5;

  // ---------------------------------------------------------------
  // priority codes (high bit, low bit)
  // ---------------------------------------------------------------
  localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
  localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
  localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
  localparam logic [1:0] PRIO_LEVEL3 = 2'h3;
  localparam logic [1:0] CUR_PRIO_RESET = 2'h3;
  localparam int CC_HIGH_BIT_POS = 5;
  localparam int CC_LOW_BIT_POS = 3;
  localparam logic [7:0] CC_FIXED_BITS = 8'hE2;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_COND_CODE = 8'h20;
  localparam logic [7:0] IDX_CTRL = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [7:0] IDX_VEC_PRIO0 = 8'h24;
  localparam logic [7:0] IDX_VEC_PRIO3 = 8'h27;
  localparam logic [7:0] VEC_PRIO_RESET = 8'hFF;
  localparam logic [7:0] VEC_PRIO3_RO_ONES = 8'hF0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_NESTED_POS = 0;
  localparam int CTRL_SPI_SLAVE_POS = 1;
  localparam int CTRL_ART_EXTCLK_POS = 2;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;

  // ---------------------------------------------------------------
  // instruction codes reported by the sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE, OP_RIM, OP_SIM, OP_HALT, OP_WFI, OP_TRAP, OP_RETURN_FROM_IRQ_INSTR, OP_POPCC
  } instr_op_t;

  // code to numeric level, 0 lowest, 3 masks all but the top pin
  function automatic logic [2:0] prio_level(input logic [1:0] code);
    logic [2:0] lvl;
    lvl = 3'h0;
    unique case (code)
      PRIO_LEVEL0: lvl = 3'h0;
      PRIO_LEVEL1: lvl = 3'h1;
      PRIO_LEVEL2: lvl = 3'h2;
      PRIO_LEVEL3: lvl = 3'h3;
    endcase
    return lvl;
  endfunction : prio_level

endpackage : nested_irq_pkg

// ==== hdl/nested_priority_interrupt_controller.sv ====
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nested_priority_interrupt_controller
  import nested_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // peripheral side
  input wire logic [13:0] src_flag,
  input wire logic [13:0] src_enable,
  input wire logic [13:0] src_clear,
  input wire logic top_level_pin_irq,
  input wire logic ext_line_zero,
  input wire logic ext_line_one,
  input wire logic ext_line_two,
  input wire logic ext_line_three,
  // instruction sequencer side
  input wire logic instr_end,
  input wire instr_op_t instr_op,
  input wire logic [1:0] pop_prio,
  output logic irq_request,
  output logic vec_take,
  output logic [15:0] vec_addr,
  output logic [3:0] vec_index,
  output logic cur_prio_high_bit,
  output logic cur_prio_low_bit,
  output logic branch_if_masked,
  output logic branch_if_unmasked,
  output logic cpu_wake,
  output logic in_halt,
  output logic in_wait,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0] vp_reg [4];
  logic [7:0] ctrl_reg;
  logic [1:0] cur_prio_reg;
  logic [13:0] pend_reg;
  logic [3:0] depth_reg;
  logic in_tli_reg;
  logic halt_reg;
  logic wait_reg;
  logic halt_exit_reg;
  logic [NUM_PINS-1:0] pin_s1, pin_s2, pin_s3, pin_lvl;
  logic [NUM_PINS-1:0] pin_rise;
  logic [13:0] set_evt;
  logic [13:0] wake_cap;
  logic [13:0] elig;
  logic [2:0] cur_lvl;
  logic found;
  logic [3:0] win_idx;
  logic [2:0] win_lvl;
  logic [1:0] win_code;
  logic take_trap;
  logic take_irq;
  logic [31:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic do_write;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_val;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [NUM_PINS-1:0] pins_in;
  assign pins_in = {ext_line_three, ext_line_two, ext_line_one,
                    ext_line_zero, top_level_pin_irq};

  // three stages; a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_lvl <= '0;
    end else begin
      pin_s1 <= pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_lvl[i] <= pin_s3[i];
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // request latches
  // -----------------------------------------------------------------
  // judged bit by bit, so a busy pin cannot hide another pin's edge
  assign pin_rise = pin_s3 & pin_s2 & ~pin_lvl;

  // pins raise on an edge; peripherals raise while flag and enable hold
  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_src
      if (gv == 0) begin : g_top
        assign set_evt[gv] = pin_rise[0];
      end else if (gv >= 2 && gv <= 5) begin : g_ext
        assign set_evt[gv] = pin_rise[gv-1];
      end else if (PERIPH_VEC_MASK[gv]) begin : g_per
        assign set_evt[gv] = src_flag[gv] & src_enable[gv];
      end else begin : g_none
        assign set_evt[gv] = 1'b0;
      end
    end
  endgenerate

  // a new event beats the clear on taking; the flag clear drops it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= '0;
    end else begin
      for (int v = 0; v < NUM_VEC; v++) begin
        if (PERIPH_VEC_MASK[v] && src_clear[v]) begin
          pend_reg[v] <= 1'b0;
        end else if (set_evt[v]) begin
          pend_reg[v] <= 1'b1;
        end else if (take_irq && win_idx == 4'(v)) begin
          pend_reg[v] <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // arbitration
  // -----------------------------------------------------------------
  assign cur_lvl = prio_level(cur_prio_reg);

  // wake capability, serial and reload timer depend on their mode bits
  always_comb begin
    wake_cap = HALT_WAKE_FIXED;
    wake_cap[VEC_SERIAL_SYNC] = ctrl_reg[CTRL_SPI_SLAVE_POS];
    wake_cap[VEC_AUTORELOAD] = ctrl_reg[CTRL_ART_EXTCLK_POS];
  end

  // highest level wins; walking downward with >= lets lower index win ties
  always_comb begin
    logic [2:0] lv;
    logic [1:0] pc;
    lv = 3'h0;
    pc = 2'h0;
    elig = '0;
    found = 1'b0;
    win_idx = 4'h0;
    win_lvl = 3'h0;
    win_code = PRIO_LEVEL3;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      pc = vp_reg[v / 4][2 * (v % 4) +: 2];
      lv = (v == 0) ? 3'h4 : prio_level(pc);
      if (v == 0) begin
        elig[v] = pend_reg[v] & ~in_tli_reg;
      end else begin
        elig[v] = pend_reg[v] && (lv > cur_lvl) &&
                  (ctrl_reg[CTRL_NESTED_POS] || depth_reg == 4'h0);
      end
      if ((halt_reg || halt_exit_reg) && !wake_cap[v]) begin
        elig[v] = 1'b0;
      end
      if (elig[v] && (!found || lv >= win_lvl)) begin
        found = 1'b1;
        win_idx = 4'(v);
        win_lvl = lv;
        win_code = (v == 0) ? PRIO_LEVEL3 : pc;
      end
    end
  end

  // vectors are only entered between instructions
  assign take_trap = instr_end && instr_op == OP_TRAP;
  assign take_irq = instr_end && !take_trap && found && !halt_reg &&
                    !wait_reg;

  // -----------------------------------------------------------------
  // current priority and service tracking
  // -----------------------------------------------------------------
  // vector entry outranks instruction effects and software writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_prio_reg <= CUR_PRIO_RESET;
    end else if (take_trap) begin
      cur_prio_reg <= PRIO_LEVEL3;
    end else if (take_irq) begin
      cur_prio_reg <= win_code;
    end else if (instr_end && instr_op != OP_NONE) begin
      unique case (instr_op)
        OP_RIM, OP_HALT, OP_WFI: cur_prio_reg <= PRIO_LEVEL0;
        OP_SIM: cur_prio_reg <= PRIO_LEVEL3;
        OP_RETURN_FROM_IRQ_INSTR, OP_POPCC: cur_prio_reg <= pop_prio;
        default: cur_prio_reg <= cur_prio_reg;
      endcase
    end else if (do_write && wr_idx == IDX_COND_CODE && w_strb_reg[0]) begin
      cur_prio_reg <= {w_data_reg[CC_HIGH_BIT_POS],
                       w_data_reg[CC_LOW_BIT_POS]};
    end
  end

  // nesting depth decides preemption in concurrent mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth_reg <= 4'h0;
      in_tli_reg <= 1'b0;
    end else if (take_trap || take_irq) begin
      depth_reg <= depth_reg + 4'h1;
      if (take_irq && win_idx == VEC_TOP_PIN) begin
        in_tli_reg <= 1'b1;
      end
    end else if (instr_end && instr_op == OP_RETURN_FROM_IRQ_INSTR) begin
      depth_reg <= (depth_reg == 4'h0) ? 4'h0 : depth_reg - 4'h1;
      in_tli_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // low power states
  // -----------------------------------------------------------------
  // halt_exit keeps the filter on until the first vector is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_reg <= 1'b0;
      wait_reg <= 1'b0;
      halt_exit_reg <= 1'b0;
      cpu_wake <= 1'b0;
    end else begin
      cpu_wake <= 1'b0;
      if (halt_reg && |(pend_reg & wake_cap)) begin
        halt_reg <= 1'b0;
        halt_exit_reg <= 1'b1;
        cpu_wake <= 1'b1;
      end else if (wait_reg && |pend_reg) begin
        wait_reg <= 1'b0;
        cpu_wake <= 1'b1;
      end else if (instr_end && instr_op == OP_HALT) begin
        halt_reg <= 1'b1;
      end else if (instr_end && instr_op == OP_WFI) begin
        wait_reg <= 1'b1;
      end
      if (take_irq || take_trap) begin
        halt_exit_reg <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs to the sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_take <= 1'b0;
      vec_addr <= ADDR_RESET_VEC;
      vec_index <= 4'h0;
      irq_request <= 1'b0;
    end else begin
      vec_take <= take_trap | take_irq;
      irq_request <= found & ~take_irq;
      if (take_trap) begin
        vec_addr <= ADDR_TRAP_VEC;
      end else if (take_irq) begin
        vec_addr <= ADDR_VEC0 - {11'h0, win_idx, 1'b0};
        vec_index <= win_idx;
      end
    end
  end

  // branch flags follow the stored bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_prio_high_bit <= CUR_PRIO_RESET[1];
      cur_prio_low_bit <= CUR_PRIO_RESET[0];
      branch_if_masked <= 1'b1;
      branch_if_unmasked <= 1'b0;
      in_halt <= 1'b0;
      in_wait <= 1'b0;
    end else begin
      cur_prio_high_bit <= cur_prio_reg[1];
      cur_prio_low_bit <= cur_prio_reg[0];
      branch_if_masked <= cur_prio_reg == PRIO_LEVEL3;
      branch_if_unmasked <= cur_prio_reg != PRIO_LEVEL3;
      in_halt <= halt_reg;
      in_wait <= wait_reg;
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite write path
  // -----------------------------------------------------------------
  assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wr_idx = aw_addr_reg[9:2];
  assign wr_hit = (wr_idx >= IDX_COND_CODE && wr_idx <= IDX_STATUS) ||
                  (wr_idx >= IDX_VEC_PRIO0 && wr_idx <= IDX_VEC_PRIO3);

  // address and data are held separately, so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      s_axi_awready <= ~aw_got_reg & ~s_axi_bvalid &
                       ~(s_axi_awvalid & s_axi_awready) & ~do_write;
      s_axi_wready <= ~w_got_reg & ~s_axi_bvalid &
                      ~(s_axi_wvalid & s_axi_wready) & ~do_write;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // priority pairs refuse the level 0 code, pair by pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < 4; r++) begin
        vp_reg[r] <= VEC_PRIO_RESET;
      end
      ctrl_reg <= CTRL_RESET;
    end else if (do_write && w_strb_reg[0]) begin
      if (wr_idx == IDX_CTRL) begin
        ctrl_reg <= {5'h0, w_data_reg[2:0]};
      end
      for (int r = 0; r < 4; r++) begin
        if (wr_idx == IDX_VEC_PRIO0 + 8'(r)) begin
          for (int p = 0; p < 4; p++) begin
            if (w_data_reg[2 * p +: 2] != PRIO_LEVEL0) begin
              vp_reg[r][2 * p +: 2] <= w_data_reg[2 * p +: 2];
            end
          end
          if (r == 3) begin
            vp_reg[r][7:4] <= VEC_PRIO3_RO_ONES[7:4];
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite read path
  // -----------------------------------------------------------------
  assign rd_idx = s_axi_araddr[9:2];

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (rd_idx == IDX_COND_CODE) begin
      rd_val = CC_FIXED_BITS;
      rd_val[CC_HIGH_BIT_POS] = cur_prio_reg[1];
      rd_val[CC_LOW_BIT_POS] = cur_prio_reg[0];
    end else if (rd_idx == IDX_CTRL) begin
      rd_val = ctrl_reg;
    end else if (rd_idx >= IDX_VEC_PRIO0 && rd_idx <= IDX_VEC_PRIO3) begin
      rd_val = vp_reg[rd_idx[1:0]];
    end else if (rd_idx != IDX_STATUS) begin
      rd_hit = 1'b0;
    end
  end

  // status word shows pending latches and the current state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_DECERR;
        if (rd_idx == IDX_STATUS) begin
          s_axi_rdata <= {8'h0, depth_reg, halt_exit_reg, wait_reg,
                          halt_reg, in_tli_reg, 2'h0, pend_reg};
        end else begin
          s_axi_rdata <= {24'h0, rd_val};
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : nested_priority_interrupt_controller
`default_nettype wire

// ==== test/periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] raise,
  input wire logic [13:0] src_clear,
  output logic [13:0] src_flag
);
  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  // flag holds until its clearing sequence, never drops by itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_flag <= '0;
    end else begin
      src_flag <= (src_flag | raise) & ~src_clear;
    end
  end
endmodule : periph_model
`default_nettype wire

// ==== test/nested_irq_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module nested_irq_chk
  import nested_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_end,
  input wire instr_op_t instr_op,
  input wire logic [1:0] pop_prio,
  input wire logic vec_take,
  input wire logic [15:0] vec_addr,
  input wire logic [3:0] vec_index,
  input wire logic cur_prio_high_bit,
  input wire logic cur_prio_low_bit,
  input wire logic branch_if_masked,
  input wire logic branch_if_unmasked,
  input wire logic in_halt,
  input wire logic in_wait,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  logic [1:0] cur;
  logic run;
  // interrupt vectors are refused while asleep, though trap is not; trap is only judged awake
  assign cur = {cur_prio_high_bit, cur_prio_low_bit};
  assign run = !in_halt && !in_wait;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_trap_taken: assert property (
    instr_end && instr_op == OP_TRAP && run
    |=> vec_take && vec_addr == ADDR_TRAP_VEC)
    else $error("trap vector not entered");
  a_enable_level: assert property (
    (instr_end && instr_op == OP_RIM) ##1 !vec_take |=> cur == PRIO_LEVEL0)
    else $error("enable did not load level 0");
  a_disable_level: assert property (
    (instr_end && instr_op == OP_SIM) ##1 !vec_take |=> cur == PRIO_LEVEL3)
    else $error("disable did not load level 3");
  a_return_level: assert property (
    (instr_end && instr_op == OP_RETURN_FROM_IRQ_INSTR) ##1 !vec_take
    |=> cur == $past(pop_prio, 2))
    else $error("return did not restore level");
  a_branch_flags: assert property (
    $stable(cur) |-> branch_if_masked == (cur == PRIO_LEVEL3)
    && branch_if_unmasked == (cur != PRIO_LEVEL3))
    else $error("branch flags disagree with level");
  a_vector_map: assert property (
    vec_take && vec_addr < ADDR_VEC0
    |-> vec_addr == ADDR_VEC0 - {11'h0, vec_index, 1'b0}
    && vec_index != VEC_UNUSED)
    else $error("vector address does not match index");
  a_take_cause: assert property (
    vec_take |-> $past(instr_end))
    else $error("vector taken outside instruction end");
  a_fixed_level: assert property (
    vec_take && vec_addr >= ADDR_VEC0 |=> cur == PRIO_LEVEL3)
    else $error("fixed vector did not set level 3");
  // spacing guard: a level change may still be on its way to the port
  a_level3_mask: assert property (
    instr_end && cur == PRIO_LEVEL3 && instr_op != OP_TRAP
    && !$past(instr_end) && !$past(instr_end, 2)
    |=> !vec_take || vec_addr >= ADDR_VEC0)
    else $error("maskable vector taken at level 3");
  a_write_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule : nested_irq_chk
bind nested_priority_interrupt_controller nested_irq_chk chk_i (.*);
`default_nettype wire

// ==== test/tb_nested_priority_interrupt_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_nested_priority_interrupt_controller
  import nested_irq_pkg::*;
;
  // ------------------------------------------------------------
  // signals and parts
  // ------------------------------------------------------------
  logic aclk, aresetn, instr_end, top_level_pin_irq;
  logic ext_line_zero, ext_line_one, ext_line_two, ext_line_three;
  logic [13:0] src_flag, src_enable, src_clear, raise;
  instr_op_t instr_op;
  logic [1:0] pop_prio, s_axi_bresp, s_axi_rresp;
  logic irq_request, vec_take, cur_prio_high_bit, cur_prio_low_bit;
  logic branch_if_masked, branch_if_unmasked, cpu_wake, in_halt, in_wait;
  logic [15:0] vec_addr;
  logic [3:0] vec_index, s_axi_wstrb;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int fail_count, n_compared;
  nested_priority_interrupt_controller DUT (.*);
  periph_model peers (.aclk(aclk), .aresetn(aresetn), .raise(raise),
    .src_clear(src_clear), .src_flag(src_flag));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // write holds each channel until its own ready
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    chk(s_axi_bresp, AXI_OKAY);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [7:0] e,
      input logic [1:0] re);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    chk(s_axi_rdata[7:0], e);
    chk(s_axi_rresp, re);
    s_axi_rready <= 1'b0;
  endtask : rd
  // one instruction end, then take and level checked where settled
  task automatic step(input instr_op_t op, input logic [1:0] pp,
      input logic tk, input logic [15:0] ad, input logic [1:0] cu);
    @(posedge aclk);
    instr_end <= 1'b1;
    instr_op <= op;
    pop_prio <= pp;
    @(posedge aclk);
    instr_end <= 1'b0;
    instr_op <= OP_NONE;
    @(negedge aclk);
    chk(vec_take, tk);
    if (tk) chk(vec_addr, ad);
    if (tk && ad < ADDR_VEC0) chk(vec_index, (ADDR_VEC0 - ad) >> 1);
    @(negedge aclk);
    chk({cur_prio_high_bit, cur_prio_low_bit}, cu);
    chk(branch_if_unmasked, cu != PRIO_LEVEL3);
  endtask : step
  task automatic pulse(input logic [13:0] r, input logic [13:0] c);
    @(posedge aclk);
    raise <= r;
    src_clear <= c;
    @(posedge aclk);
    raise <= '0;
    src_clear <= '0;
    repeat (3) @(posedge aclk);
  endtask : pulse
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {aresetn, instr_end, top_level_pin_irq, s_axi_awvalid} = '0;
    {ext_line_zero, ext_line_one, ext_line_two, ext_line_three} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {src_enable, src_clear, raise, pop_prio} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    instr_op = OP_NONE;
    s_axi_wstrb = 4'hF;
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(vec_addr, ADDR_RESET_VEC);
    chk({cur_prio_high_bit, cur_prio_low_bit}, CUR_PRIO_RESET);
    chk(branch_if_masked, 1'b1);
    for (int i = 0; i < 4; i++) rd(32'h90 + 32'(4 * i), 8'hFF, AXI_OKAY);
    rd(32'h80, 8'hEA, AXI_OKAY);
    $display("test reset done");
    wr(32'h90, 8'hCF);
    wr(32'h90, 8'h64);
    rd(32'h90, 8'h44, AXI_OKAY);
    wr(32'h9C, 8'h00);
    rd(32'h9C, 8'hF0, AXI_OKAY);
    rd(32'hFC, 8'h00, AXI_DECERR);
    $display("test registers done");
    step(OP_RIM, 2'h0, 1'b0, 16'h0, PRIO_LEVEL0);
    step(OP_SIM, 2'h0, 1'b0, 16'h0, PRIO_LEVEL3);
    step(OP_TRAP, 2'h0, 1'b1, ADDR_TRAP_VEC, PRIO_LEVEL3);
    step(OP_RETURN_FROM_IRQ_INSTR, PRIO_LEVEL0, 1'b0, 16'h0, PRIO_LEVEL0);
    $display("test levels done");
    // vector 8 at level 1, vectors 9 to 11 at level 2
    wr(32'h98, 8'h01);
    pulse(14'h0100, 14'h0);
    step(OP_NONE, 2'h0, 1'b0, 16'h0, PRIO_LEVEL0);
    @(posedge aclk);
    src_enable <= 14'h3FFF;
    repeat (2) @(posedge aclk);
    step(OP_NONE, 2'h0, 1'b1, 16'hFFEA, PRIO_LEVEL1);
    pulse(14'h0200, 14'h0);
    step(OP_NONE, 2'h0, 1'b0, 16'h0, PRIO_LEVEL1);
    wr(32'h84, 8'h01);
    step(OP_NONE, 2'h0, 1'b1, 16'hFFE8, PRIO_LEVEL2);
    pulse(14'h0400, 14'h0300);
    step(OP_NONE, 2'h0, 1'b0, 16'h0, PRIO_LEVEL2);
    step(OP_RETURN_FROM_IRQ_INSTR, PRIO_LEVEL1, 1'b0, 16'h0, PRIO_LEVEL1);
    step(OP_NONE, 2'h0, 1'b1, 16'hFFE6, PRIO_LEVEL2);
    pulse(14'h0, 14'h0400);
    step(OP_RETURN_FROM_IRQ_INSTR, PRIO_LEVEL1, 1'b0, 16'h0, PRIO_LEVEL1);
    step(OP_RETURN_FROM_IRQ_INSTR, PRIO_LEVEL0, 1'b0, 16'h0, PRIO_LEVEL0);
    $display("test nesting done");
    pulse(14'h0600, 14'h0);
    step(OP_NONE, 2'h0, 1'b1, 16'hFFE8, PRIO_LEVEL2);
    pulse(14'h0, 14'h0600);
    step(OP_RETURN_FROM_IRQ_INSTR, PRIO_LEVEL0, 1'b0, 16'h0, PRIO_LEVEL0);
    $display("test order done");
    step(OP_SIM, 2'h0, 1'b0, 16'h0, PRIO_LEVEL3);
    pulse(14'h0800, 14'h0);
    step(OP_NONE, 2'h0, 1'b0, 16'h0, PRIO_LEVEL3);
    pulse(14'h0, 14'h0800);
    step(OP_RIM, 2'h0, 1'b0, 16'h0, PRIO_LEVEL0);
    step(OP_NONE, 2'h0, 1'b0, 16'h0, PRIO_LEVEL0);
    $display("test discard done");
    step(OP_SIM, 2'h0, 1'b0, 16'h0, PRIO_LEVEL3);
    @(posedge aclk);
    top_level_pin_irq <= 1'b1;
    repeat (6) @(posedge aclk);
    top_level_pin_irq <= 1'b0;
    step(OP_NONE, 2'h0, 1'b1, ADDR_VEC0, PRIO_LEVEL3);
    step(OP_RETURN_FROM_IRQ_INSTR, PRIO_LEVEL3, 1'b0, 16'h0, PRIO_LEVEL3);
    $display("test top pin done");
    // vector 9 cannot wake; line one wakes the core and goes first
    pulse(14'h0200, 14'h0);
    step(OP_HALT, 2'h0, 1'b0, 16'h0, PRIO_LEVEL0);
    chk(in_halt, 1'b1);
    @(posedge aclk);
    ext_line_one <= 1'b1;
    repeat (5) @(posedge aclk);
    @(negedge aclk);
    chk(cpu_wake, 1'b1);
    step(OP_NONE, 2'h0, 1'b1, 16'hFFF4, PRIO_LEVEL1);
    chk(in_halt, 1'b0);
    step(OP_NONE, 2'h0, 1'b1, 16'hFFE8, PRIO_LEVEL2);
    $display("test halt done");
    final_report();
  end
  // watchdog: the tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule : tb_nested_priority_interrupt_controller
`default_nettype wire
